// ==== core/bscr_regs.vh ====
`ifndef BSCR_REGS_VH
`define BSCR_REGS_VH

// ----------------------------------------
// register word indices
// ----------------------------------------
`define BSCR_IDX_FW_ID        5'h02
`define BSCR_IDX_CLK_CTRL     5'h04
`define BSCR_IDX_RELOAD_CTRL  5'h05
`define BSCR_IDX_STATUS       5'h06
`define BSCR_IDX_I2C_SET      5'h0D
`define BSCR_IDX_I2C_CMD      5'h0E
`define BSCR_IDX_I2C_REPLY    5'h0F

// ----------------------------------------
// clock circuit control fields
// ----------------------------------------
`define BSCR_CC_MULT_SEL      0
`define BSCR_CC_CHIP_RESET    1
`define BSCR_CC_OUT_EN        2
`define BSCR_CC_SYN_PWR       4
`define BSCR_CC_SYN_REF       5
`define BSCR_CC_SYN_SYNC      6
`define BSCR_CC_SYN_USER      7
`define BSCR_CC_BP_DRV        8
`define BSCR_CC_XB_LO         12
`define BSCR_CC_XB_HI         13
`define BSCR_CC_XA_BASE       16
`define BSCR_CC_MASK          32'h00FF31F7
`define BSCR_CC_RESET         32'h00000000

// ----------------------------------------
// firmware reload fields
// ----------------------------------------
`define BSCR_RL_PAGE_HI       1
`define BSCR_RL_LOAD          4
`define BSCR_RL_MASK          32'h00000013
`define BSCR_RL_RESET         32'h00000000

// ----------------------------------------
// status fields
// ----------------------------------------
`define BSCR_ST_PHY_IRQ       16
`define BSCR_ST_MEZZ1         17
`define BSCR_ST_MEZZ2         18
`define BSCR_ST_CPLD_RST      19
`define BSCR_ST_CPLD_BUS      20
`define BSCR_ST_LOCK          28

// ----------------------------------------
// serial management fields
// ----------------------------------------
`define BSCR_SET_BUS_SEL      10
`define BSCR_SET_ENABLE       11
`define BSCR_SET_MASK         32'h00000FFF
`define BSCR_SET_RESET        32'h00000000
`define BSCR_CMD_DIR          23
`define BSCR_CMD_WIDE         25
`define BSCR_CMD_LAUNCH       31
`define BSCR_CMD_MASK         32'h02FF00FF
`define BSCR_RPL_STAT         26
`define BSCR_STAT_PEND        2'h0
`define BSCR_STAT_OK          2'h1
`define BSCR_STAT_FAIL        2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define BSCR_I2C_REF_KHZ      62500
`define BSCR_CORE_KHZ         20000
`define BSCR_QTR_STEP         26'h003D090
`define BSCR_PRESC_MIN        10'h00D

`endif

// ==== core/bscr_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "bscr_regs.vh"

// Contract
// - ctrl bit 0 drives refclk multiplier select, 0 = x2.5, 1 = x1.25.
// - ctrl bit 1 drives refclk chip reset, bit 2 its output enable.
// - ctrl bit 4 powers synthesizer up, bit 5 selects CLK1 when 1.
// - ctrl bit 6 drives synthesizer sync; software raises it to resync.
// - ctrl bit 7 hands synthesizer control lines to user logic when 1.
// - ctrl bit 8 enables backplane clock driver.
// - ctrl bits 13:12 select crosspoint B out1; 23:16 crosspoint A out1-4.
// - select pair first,second bit: 00 in1, 01 in2, 10 in3, 11 in4.
// - reload bits 1:0 pick flash page; setting bit 4 triggers reload.
// - status triplets per optical module: absent, rx signal lost, tx fault.
// - status bit 16 shows PHY interrupt pending.
// - status bits 17, 18 show mezzanine 1, 2 present.
// - status bit 19 shows CPLD reset line, bits 25:20 CPLD bus.
// - status bit 28 shows synthesizer lock.
// - dual-bus I2C master for bench use; crate mode leaves devices alone.
// - SCL kHz equals 62500 divided by settings prescaler bits 9:0, taken as 13 when below 13.
// - settings bit 10 selects PHY bus, bit 11 enables, bit 12 kept 0.
// - command bits 7:0 write byte, bits 22:16 target address.
// - command bit 23: 0 read, 1 write.
// - command bit 25 selects a 16-bit read; a write always sends one byte.
// - writing command bit 31 launches; bit self-clears.
// - reply bits 27:26: 01 ok, 11 fail, 00 pending; data in 15:0.
module bscr_top #(
  parameter [31:0] FW_ID = 32'h10000000  // arbitrary version/date code
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // register bus
  input  wire        sys_strobe,
  input  wire        sys_write,
  input  wire [4:0]  sys_addr,
  input  wire [31:0] sys_wdata,
  output reg  [31:0] sys_rdata,
  output reg         sys_ack,
  // clock circuit control
  output reg         refclk_mult_sel,
  output reg         refclk_chip_reset,
  output reg         refclk_out_enable,
  output reg         synth_power_up,
  output reg         synth_ref_sel,
  output reg         synth_sync,
  output reg         backplane_clock_drive_enable,
  output reg         crosspoint_b_out1_sel_lo,
  output reg         crosspoint_b_out1_sel_hi,
  output reg  [3:0]  crosspoint_a_sel_lo,
  output reg  [3:0]  crosspoint_a_sel_hi,
  // user side synthesizer control
  input  wire        user_synth_power_up,
  input  wire        user_synth_ref_sel,
  input  wire        user_synth_sync,
  // firmware reload
  output reg  [1:0]  flash_page_sel,
  output reg         firmware_reload,
  // external status lines
  input  wire [3:0]  optical_module_absent,
  input  wire [3:0]  receive_signal_lost,
  input  wire [3:0]  transmit_fault,
  input  wire        phy_irq,
  input  wire        mezzanine1_present,
  input  wire        mezzanine2_present,
  input  wire        cpld_reset,
  input  wire [5:0]  cpld_link_bus_state,
  input  wire        synth_locked,
  input  wire        crate_mode,
  // general serial bus, open drain
  input  wire        scl_gen_in,
  output wire        scl_gen_out,
  output reg         scl_gen_oe,
  input  wire        sda_gen_in,
  output wire        sda_gen_out,
  output reg         sda_gen_oe,
  // phy serial bus, open drain
  input  wire        scl_phy_in,
  output wire        scl_phy_out,
  output reg         scl_phy_oe,
  input  wire        sda_phy_in,
  output wire        sda_phy_out,
  output reg         sda_phy_oe
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_BIT   = 4'h4;
  localparam [3:0] ST_STOP  = 4'h8;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [31:0] cc_reg;
  reg  [31:0] rl_reg;
  reg  [31:0] set_reg;
  reg  [31:0] cmd_reg;
  reg  [31:0] st_meta_reg;
  reg  [31:0] st_sync_reg;
  reg  [3:0]  sda_meta_reg;
  reg  [3:0]  sda_sync_reg;
  reg  [3:0]  st_reg;
  reg  [1:0]  q_reg;
  reg  [3:0]  cnt_reg;
  reg  [8:0]  sh_reg;
  reg  [8:0]  rx_reg;
  reg  [1:0]  fr_reg;
  reg         fail_reg;
  reg         scl_lo_reg;
  reg         sda_lo_reg;
  reg  [1:0]  stat_reg;
  reg  [7:0]  rd_lo_reg;
  reg  [7:0]  rd_hi_reg;
  reg  [25:0] acc_reg;
  wire [31:0] st_raw;
  wire        access;
  wire        wr_acc;
  wire        i2c_en;
  wire        busy;
  wire        launch;
  wire        bus_phy;
  wire        is_wr;
  wire        wide;
  wire        sda_s;
  wire        tx_frame;
  wire [9:0]  presc;
  wire [25:0] thr;
  wire [25:0] acc_sum;
  wire        tick;
  reg  [31:0] rd_mux;

  // open-drain lines only ever pull low
  assign scl_gen_out = 1'b0;
  assign sda_gen_out = 1'b0;
  assign scl_phy_out = 1'b0;
  assign sda_phy_out = 1'b0;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  // one wait state; ack lasts one cycle, master drops strobe or starts anew
  assign access = sys_strobe & ~sys_ack;
  assign wr_acc = access & sys_write;

  always @* begin
    case (sys_addr)
      `BSCR_IDX_FW_ID:       rd_mux = FW_ID;
      `BSCR_IDX_CLK_CTRL:    rd_mux = cc_reg;
      `BSCR_IDX_RELOAD_CTRL: rd_mux = rl_reg;
      `BSCR_IDX_STATUS:      rd_mux = st_sync_reg;
      `BSCR_IDX_I2C_SET:     rd_mux = set_reg;
      `BSCR_IDX_I2C_CMD:     rd_mux = cmd_reg;
      `BSCR_IDX_I2C_REPLY:   rd_mux = {4'h0, stat_reg, 10'h000, rd_hi_reg, rd_lo_reg};
      default:               rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_ack   <= 1'b0;
      sys_rdata <= 32'h00000000;
      cc_reg    <= `BSCR_CC_RESET;
      rl_reg    <= `BSCR_RL_RESET;
      set_reg   <= `BSCR_SET_RESET;
      cmd_reg   <= 32'h00000000;
    end else begin
      sys_ack <= access;
      if (access && !sys_write)
        sys_rdata <= rd_mux;
      if (wr_acc) begin
        case (sys_addr)
          `BSCR_IDX_CLK_CTRL:    cc_reg  <= sys_wdata & `BSCR_CC_MASK;
          `BSCR_IDX_RELOAD_CTRL: rl_reg  <= sys_wdata & `BSCR_RL_MASK;
          // bit 12 is not stored, it reads zero
          `BSCR_IDX_I2C_SET:     set_reg <= sys_wdata & `BSCR_SET_MASK;
          // reserved bits and the launch bit are dropped; launch reads back zero
          `BSCR_IDX_I2C_CMD: begin
            if (!busy)
              cmd_reg <= sys_wdata & `BSCR_CMD_MASK;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      refclk_mult_sel              <= 1'b0;
      refclk_chip_reset            <= 1'b0;
      refclk_out_enable            <= 1'b0;
      synth_power_up               <= 1'b0;
      synth_ref_sel                <= 1'b0;
      synth_sync                   <= 1'b0;
      backplane_clock_drive_enable <= 1'b0;
      crosspoint_b_out1_sel_lo     <= 1'b0;
      crosspoint_b_out1_sel_hi     <= 1'b0;
      crosspoint_a_sel_lo          <= 4'h0;
      crosspoint_a_sel_hi          <= 4'h0;
      flash_page_sel               <= 2'h0;
      firmware_reload              <= 1'b0;
    end else begin
      refclk_mult_sel   <= cc_reg[`BSCR_CC_MULT_SEL];
      refclk_chip_reset <= cc_reg[`BSCR_CC_CHIP_RESET];
      refclk_out_enable <= cc_reg[`BSCR_CC_OUT_EN];
      if (cc_reg[`BSCR_CC_SYN_USER]) begin
        synth_power_up <= user_synth_power_up;
        synth_ref_sel  <= user_synth_ref_sel;
        synth_sync     <= user_synth_sync;
      end else begin
        synth_power_up <= cc_reg[`BSCR_CC_SYN_PWR];
        synth_ref_sel  <= cc_reg[`BSCR_CC_SYN_REF];
        // level follows the bit, so a written 0 then 1 gives the resync edge
        synth_sync     <= cc_reg[`BSCR_CC_SYN_SYNC];
      end
      backplane_clock_drive_enable <= cc_reg[`BSCR_CC_BP_DRV];
      // pins carry the pair as is: {lo,hi} = 00 in1, 01 in2, 10 in3, 11 in4
      crosspoint_b_out1_sel_lo <= cc_reg[`BSCR_CC_XB_LO];
      crosspoint_b_out1_sel_hi <= cc_reg[`BSCR_CC_XB_HI];
      crosspoint_a_sel_lo <= {cc_reg[`BSCR_CC_XA_BASE + 6], cc_reg[`BSCR_CC_XA_BASE + 4],
                              cc_reg[`BSCR_CC_XA_BASE + 2], cc_reg[`BSCR_CC_XA_BASE]};
      crosspoint_a_sel_hi <= {cc_reg[`BSCR_CC_XA_BASE + 7], cc_reg[`BSCR_CC_XA_BASE + 5],
                              cc_reg[`BSCR_CC_XA_BASE + 3], cc_reg[`BSCR_CC_XA_BASE + 1]};
      flash_page_sel <= rl_reg[`BSCR_RL_PAGE_HI:0];
      // one pulse when a write takes the load bit from 0 to 1
      firmware_reload <= wr_acc && (sys_addr == `BSCR_IDX_RELOAD_CTRL) &&
                         sys_wdata[`BSCR_RL_LOAD] && !rl_reg[`BSCR_RL_LOAD];
    end
  end

  // ----------------------------------------
  // status synchronizers
  // ----------------------------------------
  assign st_raw = {3'h0, synth_locked, 2'h0, cpld_link_bus_state, cpld_reset,
                   mezzanine2_present, mezzanine1_present, phy_irq,
                   1'b0, transmit_fault[3], receive_signal_lost[3], optical_module_absent[3],
                   1'b0, transmit_fault[2], receive_signal_lost[2], optical_module_absent[2],
                   1'b0, transmit_fault[1], receive_signal_lost[1], optical_module_absent[1],
                   1'b0, transmit_fault[0], receive_signal_lost[0], optical_module_absent[0]};

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_meta_reg  <= 32'h00000000;
      st_sync_reg  <= 32'h00000000;
      sda_meta_reg <= 4'hF;
      sda_sync_reg <= 4'hF;
    end else begin
      st_meta_reg  <= st_raw;
      st_sync_reg  <= st_meta_reg;
      sda_meta_reg <= {crate_mode, sda_phy_in, sda_gen_in, 1'b1};
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // ----------------------------------------
  // serial management master
  // ----------------------------------------
  assign i2c_en   = set_reg[`BSCR_SET_ENABLE] & ~sda_sync_reg[3];
  assign busy     = (st_reg != ST_IDLE);
  assign launch   = wr_acc && (sys_addr == `BSCR_IDX_I2C_CMD) &&
                    sys_wdata[`BSCR_CMD_LAUNCH] && i2c_en && !busy;
  assign bus_phy  = set_reg[`BSCR_SET_BUS_SEL];
  assign is_wr    = cmd_reg[`BSCR_CMD_DIR];
  assign wide     = cmd_reg[`BSCR_CMD_WIDE];
  assign sda_s    = bus_phy ? sda_sync_reg[2] : sda_sync_reg[1];
  assign tx_frame = (fr_reg == 2'h0) | ((fr_reg == 2'h1) & is_wr);

  // quarter-bit tick at 4 x 62500/presc kHz, by fractional accumulation;
  // small prescalers are clamped since the core clock cannot go faster
  assign presc   = (set_reg[9:0] < `BSCR_PRESC_MIN) ? `BSCR_PRESC_MIN : set_reg[9:0];
  assign thr     = presc * 16'd`BSCR_CORE_KHZ;
  assign acc_sum = acc_reg + `BSCR_QTR_STEP;
  assign tick    = busy && (acc_sum >= thr);

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      acc_reg <= 26'h0000000;
    else if (!busy)
      acc_reg <= 26'h0000000;
    else if (tick)
      acc_reg <= acc_sum - thr;
    else
      acc_reg <= acc_sum;
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg     <= ST_IDLE;
      q_reg      <= 2'h0;
      cnt_reg    <= 4'h0;
      sh_reg     <= 9'h1FF;
      rx_reg     <= 9'h000;
      fr_reg     <= 2'h0;
      fail_reg   <= 1'b0;
      scl_lo_reg <= 1'b0;
      sda_lo_reg <= 1'b0;
      stat_reg   <= `BSCR_STAT_PEND;
      rd_lo_reg  <= 8'h00;
      rd_hi_reg  <= 8'h00;
    end else if (launch) begin
      st_reg   <= ST_START;
      q_reg    <= 2'h0;
      cnt_reg  <= 4'h0;
      fr_reg   <= 2'h0;
      fail_reg <= 1'b0;
      stat_reg <= `BSCR_STAT_PEND;
      sh_reg   <= {sys_wdata[22:16], ~sys_wdata[`BSCR_CMD_DIR], 1'b1};
    end else if (busy && !i2c_en) begin
      // disabling mid transfer abandons it and frees the lines
      st_reg     <= ST_IDLE;
      scl_lo_reg <= 1'b0;
      sda_lo_reg <= 1'b0;
      stat_reg   <= `BSCR_STAT_FAIL;
    end else if (tick) begin
      q_reg <= q_reg + 2'h1;
      case (st_reg)
        ST_START: begin
          case (q_reg)
            2'h0: begin
              scl_lo_reg <= 1'b0;
              sda_lo_reg <= 1'b0;
            end
            2'h1: sda_lo_reg <= 1'b1;
            2'h2: scl_lo_reg <= 1'b1;
            default: st_reg <= ST_BIT;
          endcase
        end
        ST_BIT: begin
          case (q_reg)
            2'h0: sda_lo_reg <= ~sh_reg[8];
            2'h1: scl_lo_reg <= 1'b0;
            2'h2: rx_reg <= {rx_reg[7:0], sda_s};
            default: begin
              scl_lo_reg <= 1'b1;
              sh_reg     <= {sh_reg[7:0], 1'b1};
              cnt_reg    <= cnt_reg + 4'h1;
              if (cnt_reg == 4'h8) begin
                cnt_reg <= 4'h0;
                if (tx_frame && rx_reg[0]) begin
                  // target did not acknowledge
                  fail_reg <= 1'b1;
                  st_reg   <= ST_STOP;
                end else begin
                  case (fr_reg)
                    2'h0: begin
                      fr_reg <= 2'h1;
                      if (is_wr)
                        sh_reg <= {cmd_reg[7:0], 1'b1};
                      else
                        sh_reg <= {8'hFF, ~wide};
                    end
                    2'h1: begin
                      if (is_wr) begin
                        st_reg <= ST_STOP;
                      end else if (wide) begin
                        rd_hi_reg <= rx_reg[8:1];
                        sh_reg    <= 9'h1FF;
                        fr_reg    <= 2'h2;
                      end else begin
                        rd_lo_reg <= rx_reg[8:1];
                        st_reg    <= ST_STOP;
                      end
                    end
                    default: begin
                      rd_lo_reg <= rx_reg[8:1];
                      st_reg    <= ST_STOP;
                    end
                  endcase
                end
              end
            end
          endcase
        end
        ST_STOP: begin
          case (q_reg)
            2'h0: begin
              scl_lo_reg <= 1'b1;
              sda_lo_reg <= 1'b1;
            end
            2'h1: scl_lo_reg <= 1'b0;
            2'h2: sda_lo_reg <= 1'b0;
            default: begin
              st_reg   <= ST_IDLE;
              stat_reg <= fail_reg ? `BSCR_STAT_FAIL : `BSCR_STAT_OK;
            end
          endcase
        end
        default: begin
          st_reg     <= ST_IDLE;
          scl_lo_reg <= 1'b0;
          sda_lo_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // bus steering
  // ----------------------------------------
  // the idle bus is never pulled, so devices on it see no traffic
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_gen_oe <= 1'b0;
      sda_gen_oe <= 1'b0;
      scl_phy_oe <= 1'b0;
      sda_phy_oe <= 1'b0;
    end else begin
      scl_gen_oe <= scl_lo_reg & ~bus_phy;
      sda_gen_oe <= sda_lo_reg & ~bus_phy;
      scl_phy_oe <= scl_lo_reg & bus_phy;
      sda_phy_oe <= sda_lo_reg & bus_phy;
    end
  end

endmodule

`default_nettype wire

// ==== tb/bscr_top_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bscr_regs.vh"
// --------------------
// register bank checker
// --------------------
module bscr_top_asserts (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // register bus
  input wire logic        sys_strobe,
  input wire logic        sys_write,
  input wire logic [4:0]  sys_addr,
  input wire logic [31:0] sys_wdata,
  input wire logic [31:0] sys_rdata,
  input wire logic        sys_ack,
  // driven pins
  input wire logic        refclk_mult_sel,
  input wire logic        refclk_chip_reset,
  input wire logic        refclk_out_enable,
  input wire logic [3:0]  crosspoint_a_sel_lo,
  input wire logic [3:0]  crosspoint_a_sel_hi,
  input wire logic        firmware_reload,
  input wire logic        scl_gen_oe,
  input wire logic        scl_phy_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // a held strobe is taken in every cycle in which no answer shows
  wire take   = sys_strobe && !sys_ack;
  wire wr_ctl = take && sys_write && sys_addr == `BSCR_IDX_CLK_CTRL;

  property p_ack_next;
    take |=> sys_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered");
  property p_ack_cause;
    sys_ack |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_ctrl_low;
    wr_ctl |-> ##2 {refclk_out_enable, refclk_chip_reset, refclk_mult_sel} == $past(sys_wdata[2:0], 2);
  endproperty
  a_ctrl_low: assert property (p_ctrl_low) else $error("refclk pins wrong");
  property p_xpt_a;
    wr_ctl |-> ##2
      crosspoint_a_sel_lo == $past({sys_wdata[22], sys_wdata[20], sys_wdata[18], sys_wdata[16]}, 2)
      && crosspoint_a_sel_hi == $past({sys_wdata[23], sys_wdata[21], sys_wdata[19], sys_wdata[17]}, 2);
  endproperty
  a_xpt_a: assert property (p_xpt_a) else $error("crosspoint pins wrong");
  property p_reload_pulse;
    firmware_reload |=> !firmware_reload;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse) else $error("reload not a pulse");
  property p_reload_cause;
    firmware_reload |->
      $past(take && sys_write && sys_addr == `BSCR_IDX_RELOAD_CTRL && sys_wdata[`BSCR_RL_LOAD]);
  endproperty
  a_reload_cause: assert property (p_reload_cause) else $error("reload without write");
  property p_cmd_rd;
    take && !sys_write && sys_addr == `BSCR_IDX_I2C_CMD |=> (sys_rdata & ~`BSCR_CMD_MASK) == 32'h0;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("launch or reserved bit read back");
  property p_bus_excl;
    !(scl_gen_oe && scl_phy_oe);
  endproperty
  a_bus_excl: assert property (p_bus_excl) else $error("both serial buses driven");
endmodule
`default_nettype wire

// ==== tb/bscr_i2c_target.sv ====
`timescale 1ns/10ps
`default_nettype none
// --------------------
// serial target on the general bus
// --------------------
module bscr_i2c_target #(
  parameter [6:0] ADDR  = 7'h2A,
  parameter [7:0] RDATA = 8'hC5
) (
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  // high pulls sda low
  output var  logic pull
);
  int         n = 0;
  logic [7:0] sh = 8'h00;
  logic       on = 1'h0, first = 1'h0, rd = 1'h0;
  initial pull = 1'h0;
  always @(negedge sda) if (scl) begin
    on = 1'h1; first = 1'h1; n = -1; pull = 1'h0;
  end
  always @(posedge sda) if (scl) begin
    on = 1'h0; pull = 1'h0;
  end
  // a refused last byte ends the frame, so sda is free for the stop
  always @(posedge scl) if (on) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd && sda) on = 1'h0;
  end
  always @(negedge scl) if (on) begin
    n = n + 1;
    if (n == 9) begin
      n = 0;
      if (first) rd = sh[0];
      first = 1'h0;
    end
    if (n == 8) pull = first ? (sh[7:1] == ADDR) : !rd;
    else if (rd && !first) pull = ~RDATA[7 - n];
    else pull = 1'h0;
  end
endmodule
`default_nettype wire

// ==== tb/tb_bscr_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bscr_regs.vh"
// --------------------
// register bank bench
// --------------------
module tb_bscr_top;
  logic        core_clk = 1'h0, rst_b = 1'h0, sys_strobe = 1'h0, sys_write = 1'h0, crate = 1'h0;
  logic [4:0]  sys_addr = 5'h00;
  logic [31:0] sys_wdata = 32'h0, q;
  logic [2:0]  usr = 3'h0;
  logic [22:0] st = 23'h0;
  wire  [31:0] sys_rdata;
  wire  [16:0] pins;
  wire  [1:0]  page;
  wire         sys_ack, reload, scl_oe, sda_oe, scl_poe, sda_poe, pull;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | pull);
  int          mismatches = 0, tests_run = 0, cyc = 0, nrel = 0, t1 = 0, per = 0, nrl = 0, n;
  logic [4:0]  ra [5] = '{`BSCR_IDX_CLK_CTRL, `BSCR_IDX_RELOAD_CTRL, `BSCR_IDX_I2C_SET,
                          `BSCR_IDX_I2C_REPLY, 5'h03};
  logic [31:0] cw [3] = '{32'h00E42015, 32'h00FF317F, 32'h00000000};
  logic [31:0] rw [4] = '{32'h00000013, 32'h00000013, 32'h00000002, 32'h00000012};
  logic [22:0] sv [2] = '{23'h2B4C1D, 23'h54B3E2};
  logic [31:0] tx [5][4] = '{'{32'h00000864, 32'h80AA0033, 32'h0C000000, 32'h04000000},
                             '{32'h00000864, 32'h822A0000, 32'h0C00FFFF, 32'h0400C5C5},
                             '{32'h00000864, 32'h802A0000, 32'h0C0000FF, 32'h040000C5},
                             '{32'h00000864, 32'h80910000, 32'h0C000000, 32'h0C000000},
                             '{32'h00000C64, 32'h802A0000, 32'h0C000000, 32'h0C000000}};
  bscr_top bscr_top_i (
    .core_clk(core_clk), .rst_b(rst_b), .sys_strobe(sys_strobe), .sys_write(sys_write),
    .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .sys_ack(sys_ack),
    .refclk_mult_sel(pins[16]), .refclk_chip_reset(pins[15]), .refclk_out_enable(pins[14]),
    .synth_power_up(pins[13]), .synth_ref_sel(pins[12]), .synth_sync(pins[11]),
    .backplane_clock_drive_enable(pins[10]), .crosspoint_b_out1_sel_lo(pins[9]),
    .crosspoint_b_out1_sel_hi(pins[8]), .crosspoint_a_sel_lo(pins[7:4]),
    .crosspoint_a_sel_hi(pins[3:0]), .user_synth_power_up(usr[2]),
    .user_synth_ref_sel(usr[1]), .user_synth_sync(usr[0]), .flash_page_sel(page),
    .firmware_reload(reload), .optical_module_absent(st[3:0]), .receive_signal_lost(st[7:4]),
    .transmit_fault(st[11:8]), .phy_irq(st[12]), .mezzanine1_present(st[13]),
    .mezzanine2_present(st[14]), .cpld_reset(st[15]), .cpld_link_bus_state(st[21:16]),
    .synth_locked(st[22]), .crate_mode(crate), .scl_gen_in(scl), .scl_gen_out(),
    .scl_gen_oe(scl_oe), .sda_gen_in(sda), .sda_gen_out(), .sda_gen_oe(sda_oe),
    .scl_phy_in(~scl_poe), .scl_phy_out(), .scl_phy_oe(scl_poe), .sda_phy_in(~sda_poe),
    .sda_phy_out(), .sda_phy_oe(sda_poe));
  bscr_i2c_target bscr_i2c_target_i (.scl(scl), .sda(sda), .pull(pull));
  always #25 core_clk = ~core_clk;
  always @(negedge scl_oe) if (rst_b) begin
    nrel++;
    if (nrel == 1) t1 = cyc;
    if (nrel == 2) per = cyc - t1;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (reload === 1'h1) nrl++;
    if (cyc == 30000) begin
      mismatches++;
      finish_test();
    end
  end
  function automatic logic [16:0] pexp(input logic [31:0] w);
    return {w[0], w[1], w[2], w[4], w[5], w[6], w[8], w[12], w[13],
            w[22], w[20], w[18], w[16], w[23], w[21], w[19], w[17]};
  endfunction
  function automatic logic [31:0] sexp(input logic [22:0] s);
    logic [31:0] e;
    e = 32'h0;
    for (int k = 0; k < 4; k++) e[4*k +: 3] = {s[8+k], s[4+k], s[k]};
    e[28:16] = {s[22], 2'h0, s[21:12]};
    return e;
  endfunction
  // request held until the edge that sees the answer, released one cycle on
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(negedge core_clk);
    sys_strobe = 1'h1; sys_write = w; sys_addr = a; sys_wdata = d; k = 0;
    do begin @(negedge core_clk); k++; end while (sys_ack !== 1'h1 && k < 8);
    if (k == 8) mismatches++;
    r = sys_rdata;
    @(posedge core_clk);
    @(negedge core_clk);
    sys_strobe = 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst_b = 1'h1;
    foreach (ra[i]) begin
      bus(1'h0, ra[i], 32'h0, q);
      chk("reset value", 32'h0, q);
    end
    bus(1'h1, `BSCR_IDX_FW_ID, 32'hFFFFFFFF, q);
    bus(1'h0, `BSCR_IDX_FW_ID, 32'h0, q);
    chk("version", 32'h10000000, q);
    $display("test reset done");
    bus(1'h1, `BSCR_IDX_CLK_CTRL, 32'hFFFFFFFF, q);
    bus(1'h0, `BSCR_IDX_CLK_CTRL, 32'h0, q);
    chk("ctrl readback", `BSCR_CC_MASK, q);
    foreach (cw[i]) begin
      bus(1'h1, `BSCR_IDX_CLK_CTRL, cw[i], q);
      repeat (2) @(negedge core_clk);
      chk("pins", {15'h0, pexp(cw[i])}, {15'h0, pins});
    end
    for (int i = 0; i < 2; i++) begin
      usr = i ? 3'h2 : 3'h5;
      bus(1'h1, `BSCR_IDX_CLK_CTRL, 32'h00000080, q);
      repeat (3) @(negedge core_clk);
      chk("user synth", {29'h0, usr}, {29'h0, pins[13:11]});
    end
    $display("test clock control done");
    foreach (rw[i]) bus(1'h1, `BSCR_IDX_RELOAD_CTRL, rw[i], q);
    repeat (2) @(negedge core_clk);
    bus(1'h0, `BSCR_IDX_RELOAD_CTRL, 32'h0, q);
    chk("reload readback", 32'h00000012, q);
    chk("reload pulses", 32'h2, nrl);
    chk("page", 32'h2, {30'h0, page});
    $display("test reload done");
    foreach (sv[i]) begin
      st = sv[i];
      repeat (4) @(negedge core_clk);
      repeat (2) begin
        bus(1'h0, `BSCR_IDX_STATUS, 32'h0, q);
        chk("status", sexp(sv[i]), q);
      end
    end
    $display("test status done");
    foreach (tx[i]) begin
      bus(1'h1, `BSCR_IDX_I2C_SET, tx[i][0], q);
      bus(1'h1, `BSCR_IDX_I2C_CMD, tx[i][1], q);
      bus(1'h0, `BSCR_IDX_I2C_REPLY, 32'h0, q);
      chk("pending", 32'h0, q & 32'h04000000);
      bus(1'h1, `BSCR_IDX_I2C_CMD, 32'h80110000, q);
      bus(1'h0, `BSCR_IDX_I2C_CMD, 32'h0, q);
      chk("command", tx[i][1] & `BSCR_CMD_MASK, q);
      n = 0;
      do begin bus(1'h0, `BSCR_IDX_I2C_REPLY, 32'h0, q); n++; end while (!q[26] && n < 600);
      chk("reply", tx[i][3], q & tx[i][2]);
    end
    chk("bit period", 32'd32, per);
    for (int i = 0; i < 2; i++) begin
      crate = i[0];
      bus(1'h1, `BSCR_IDX_I2C_SET, i ? 32'h00000864 : 32'h00000064, q);
      bus(1'h1, `BSCR_IDX_I2C_CMD, 32'h802A0000, q);
      repeat (1200) @(negedge core_clk);
      bus(1'h0, `BSCR_IDX_I2C_REPLY, 32'h0, q);
      chk("blocked", 32'h0C000000, q & 32'h0C000000);
    end
    crate = 1'h0;
    $display("test serial master done");
    finish_test();
  end
endmodule
bind bscr_top bscr_top_asserts bscr_top_asserts_i (
  .core_clk, .rst_b, .sys_strobe, .sys_write, .sys_addr, .sys_wdata, .sys_rdata, .sys_ack,
  .refclk_mult_sel, .refclk_chip_reset, .refclk_out_enable, .crosspoint_a_sel_lo,
  .crosspoint_a_sel_hi, .firmware_reload, .scl_gen_oe, .scl_phy_oe);
`default_nettype wire
